// file: verilog/cswk_params.svh
// constants for the selective-wake register bank and its controller
`ifndef CSWK_PARAMS_SVH
`define CSWK_PARAMS_SVH

// ----------------------------------------
// device register offsets (7-bit link addresses)
// ----------------------------------------
`define CSWK_OFF_WAKE_CONTROL 7'h20
`define CSWK_OFF_BIT_QUANTA 7'h21
`define CSWK_OFF_SAMPLE_POINT 7'h22
`define CSWK_OFF_IDENT_BYTE3 7'h23
`define CSWK_OFF_IDENT_BYTE2 7'h24
`define CSWK_OFF_IDENT_BYTE1 7'h25
`define CSWK_OFF_IDENT_LOW 7'h26
`define CSWK_OFF_MASK_BYTE3 7'h27
`define CSWK_OFF_LP_RX_OPTION 7'h4f
`define CSWK_OFF_BUS_STATUS 7'h4e

// ----------------------------------------
// device reset values
// ----------------------------------------
`define CSWK_RST_WAKE_CONTROL 8'h00
`define CSWK_RST_BIT_QUANTA 8'ha0
`define CSWK_RST_SAMPLE_POINT 8'h33
`define CSWK_RST_IDENT 8'h00
`define CSWK_RST_LP_RX_OPTION 8'h00

// ----------------------------------------
// field positions and writable masks
// ----------------------------------------
`define CSWK_BIT_OSC_CALIBRATION_ON 7
`define CSWK_BIT_TRIM_HI 6
`define CSWK_BIT_TRIM_LO 5
`define CSWK_BIT_TIMEOUT_ALLOW 4
`define CSWK_BIT_CFG_VALID 0
`define CSWK_TRIM_UNLOCK 2'h3
`define CSWK_WMASK_CONTROL 8'hf1
`define CSWK_WMASK_RESTART_KEEP 8'hf0
`define CSWK_WMASK_SAMPLE_POINT 8'h3f
`define CSWK_WMASK_IDENT_LOW 8'h7f
`define CSWK_BIT_RTR 1
`define CSWK_BIT_IDE 0
`define CSWK_BIT_TIMEOUT_FLAG 0

// ----------------------------------------
// controller AXI4-Lite register offsets and fields
// ----------------------------------------
`define CSWK_AXI_OFF_COMMAND 8'h00
`define CSWK_AXI_OFF_STATUS 8'h04
`define CSWK_AXI_OFF_PIN 8'h08
`define CSWK_CMD_BIT_READ 16
`define CSWK_RESP_OKAY 2'h0
`define CSWK_RESP_SLVERR 2'h2

`endif

// file: verilog/cswk_pkg.sv
// types shared by the selective-wake device and its controller
package cswk_pkg;

	// ----------------------------------------
	// device state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] bit_quanta;
		logic [7:0] sample_point;
		logic [7:0] ident3;
		logic [7:0] ident2;
		logic [7:0] ident1;
		logic [7:0] ident_low;
		logic [7:0] mask3;
		logic [7:0] lp_rx_option;
		logic timeout_flag;
		logic irq_n;
		logic [7:0] rdata;
		logic ack;
		logic match;
		logic calib_on;
		logic calib_ref;
	} cswk_dev_state_t;

	// ----------------------------------------
	// controller state
	// ----------------------------------------
	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_held;
		logic w_held;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] command;
		logic busy;
		logic [7:0] last_rdata;
		logic tx_level;
		logic link_req;
		logic link_write;
		logic [6:0] link_addr;
		logic [7:0] link_wdata;
	} cswk_host_state_t;

endpackage

// file: verilog/cswk_link_if.sv
// link between the controller and the selective-wake register bank
`timescale 1ns/10ps
interface cswk_link_if;
	logic link_req;
	logic link_write;
	logic [6:0] link_addr;
	logic [7:0] link_wdata;
	logic [7:0] link_rdata;
	logic link_ack;
	logic bus_transmit_input;
	logic interrupt_out_n;

	modport device (
		input link_req,
		input link_write,
		input link_addr,
		input link_wdata,
		output link_rdata,
		output link_ack,
		input bus_transmit_input,
		output interrupt_out_n
	);

	modport host (
		output link_req,
		output link_write,
		output link_addr,
		output link_wdata,
		input link_rdata,
		input link_ack,
		output bus_transmit_input,
		input interrupt_out_n
	);
endinterface

// file: verilog/cswk_device.sv
// selective-wake configuration register bank, device end
//
// Added by the designer: the AXI4-Lite slave port, in the controller (cswk_host), not in this module.
`timescale 1ns/10ps
`include "cswk_params.svh"
module cswk_device (
	input wire logic aclk,
	input wire logic aresetn,
	cswk_link_if.device link,
	input wire logic soft_reset,
	input wire logic chip_restart,
	input wire logic wake_up_event,
	input wire logic bus_timeout_event,
	input wire logic rx_frame_valid,
	input wire logic [28:0] rx_ident,
	input wire logic rx_rtr,
	input wire logic rx_ide,
	output logic wake_enabled,
	output logic osc_calibration_on,
	output logic calib_reference,
	output logic [7:0] quanta_per_bit,
	output logic [5:0] sample_point,
	output logic [7:0] low_power_rx_option_reg,
	output logic bus_timeout_flag,
	output logic wake_frame_match
);

	// ----------------------------------------
	// state and reset image
	// ----------------------------------------
	cswk_pkg::cswk_dev_state_t state_r;
	cswk_pkg::cswk_dev_state_t state_nxt;

	function automatic cswk_pkg::cswk_dev_state_t reset_image();
		cswk_pkg::cswk_dev_state_t r;
		r = '0;
		r.control = `CSWK_RST_WAKE_CONTROL;
		r.bit_quanta = `CSWK_RST_BIT_QUANTA;
		r.sample_point = `CSWK_RST_SAMPLE_POINT;
		r.ident3 = `CSWK_RST_IDENT;
		r.ident2 = `CSWK_RST_IDENT;
		r.ident1 = `CSWK_RST_IDENT;
		r.ident_low = `CSWK_RST_IDENT;
		r.mask3 = `CSWK_RST_IDENT;
		r.lp_rx_option = `CSWK_RST_LP_RX_OPTION;
		r.irq_n = 1'b1;
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic wr;
	logic cfg_wr;
	logic valid_set;
	logic unlocked;
	logic [28:0] cfg_ident;
	logic [28:0] cmp_mask;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.ack = 1'b0;
		state_nxt.match = 1'b0;
		wr = link.link_req & link.link_write;
		cfg_wr = 1'b0;
		valid_set = 1'b0;
		unlocked = state_r.control[`CSWK_BIT_TRIM_HI:`CSWK_BIT_TRIM_LO] == `CSWK_TRIM_UNLOCK;
		cfg_ident = {state_r.ident3, state_r.ident2, state_r.ident1,
			state_r.ident_low[6:2]};
		cmp_mask = {state_r.mask3, 21'h1fffff};
		if (!state_r.ident_low[`CSWK_BIT_IDE])
		begin
			cmp_mask[17:0] = 18'h00000;
		end
		if (wr)
		begin
			unique case (link.link_addr)
				`CSWK_OFF_WAKE_CONTROL:
				begin
					state_nxt.control = link.link_wdata & `CSWK_WMASK_CONTROL;
					valid_set = link.link_wdata[`CSWK_BIT_CFG_VALID];
				end
				`CSWK_OFF_BIT_QUANTA:
				begin
					state_nxt.bit_quanta = link.link_wdata;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_SAMPLE_POINT:
				begin
					state_nxt.sample_point = link.link_wdata & `CSWK_WMASK_SAMPLE_POINT;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_IDENT_BYTE3:
				begin
					state_nxt.ident3 = link.link_wdata;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_IDENT_BYTE2:
				begin
					state_nxt.ident2 = link.link_wdata;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_IDENT_BYTE1:
				begin
					state_nxt.ident1 = link.link_wdata;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_IDENT_LOW:
				begin
					state_nxt.ident_low = link.link_wdata & `CSWK_WMASK_IDENT_LOW;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_MASK_BYTE3:
				begin
					state_nxt.mask3 = link.link_wdata;
					cfg_wr = 1'b1;
				end
				`CSWK_OFF_LP_RX_OPTION:
				begin
					if (unlocked)
					begin
						state_nxt.lp_rx_option = link.link_wdata;
						cfg_wr = 1'b1;
					end
				end
				`CSWK_OFF_BUS_STATUS:
				begin
					if (link.link_wdata[`CSWK_BIT_TIMEOUT_FLAG])
					begin
						state_nxt.timeout_flag = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end
		// automatic clear of the valid flag, a software set wins
		if ((cfg_wr | wake_up_event) & !valid_set)
		begin
			state_nxt.control[`CSWK_BIT_CFG_VALID] = 1'b0;
		end
		// timeout event wins over the clear
		if (bus_timeout_event & state_r.control[`CSWK_BIT_CFG_VALID])
		begin
			state_nxt.timeout_flag = 1'b1;
		end
		if (rx_frame_valid & state_r.control[`CSWK_BIT_CFG_VALID])
		begin
			state_nxt.match = (((rx_ident ^ cfg_ident) & cmp_mask) == 29'h00000000)
				& (rx_rtr == state_r.ident_low[`CSWK_BIT_RTR])
				& (rx_ide == state_r.ident_low[`CSWK_BIT_IDE]);
		end
		if (link.link_req)
		begin
			state_nxt.ack = 1'b1;
			unique case (link.link_addr)
				`CSWK_OFF_WAKE_CONTROL: state_nxt.rdata = state_r.control;
				`CSWK_OFF_BIT_QUANTA: state_nxt.rdata = state_r.bit_quanta;
				`CSWK_OFF_SAMPLE_POINT: state_nxt.rdata = state_r.sample_point;
				`CSWK_OFF_IDENT_BYTE3: state_nxt.rdata = state_r.ident3;
				`CSWK_OFF_IDENT_BYTE2: state_nxt.rdata = state_r.ident2;
				`CSWK_OFF_IDENT_BYTE1: state_nxt.rdata = state_r.ident1;
				`CSWK_OFF_IDENT_LOW: state_nxt.rdata = state_r.ident_low;
				`CSWK_OFF_MASK_BYTE3: state_nxt.rdata = state_r.mask3;
				`CSWK_OFF_LP_RX_OPTION: state_nxt.rdata = state_r.lp_rx_option;
				`CSWK_OFF_BUS_STATUS: state_nxt.rdata = {7'h00, state_r.timeout_flag};
				default: state_nxt.rdata = 8'h00;
			endcase
		end
		if (chip_restart)
		begin
			state_nxt.control = state_r.control & `CSWK_WMASK_RESTART_KEEP;
		end
		if (soft_reset)
		begin
			state_nxt = reset_image();
		end
		state_nxt.irq_n = !(state_nxt.timeout_flag
			& state_nxt.control[`CSWK_BIT_TIMEOUT_ALLOW]);
		state_nxt.calib_on = state_nxt.control[`CSWK_BIT_OSC_CALIBRATION_ON]
			& (state_nxt.control[`CSWK_BIT_TRIM_HI:`CSWK_BIT_TRIM_LO]
			== `CSWK_TRIM_UNLOCK);
		state_nxt.calib_ref = state_nxt.calib_on & link.bus_transmit_input;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= reset_image();
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.link_rdata = state_r.rdata;
	assign link.link_ack = state_r.ack;
	assign link.interrupt_out_n = state_r.irq_n;
	assign wake_enabled = state_r.control[`CSWK_BIT_CFG_VALID];
	assign osc_calibration_on = state_r.calib_on;
	assign calib_reference = state_r.calib_ref;
	assign quanta_per_bit = state_r.bit_quanta;
	assign sample_point = state_r.sample_point[5:0];
	assign low_power_rx_option_reg = state_r.lp_rx_option;
	assign bus_timeout_flag = state_r.timeout_flag;
	assign wake_frame_match = state_r.match;

endmodule

// file: verilog/cswk_host.sv
// controller end: AXI4-Lite slave that drives the register link
`timescale 1ns/10ps
`include "cswk_params.svh"
module cswk_host (
	input wire logic aclk,
	input wire logic aresetn,
	cswk_link_if.host link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	cswk_pkg::cswk_host_state_t state_r;
	cswk_pkg::cswk_host_state_t state_nxt;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [31:0] cmd;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.link_req = 1'b0;
		cmd = merge_bytes(state_r.command, state_r.wdata, state_r.wstrb);
		if (s_axi_awvalid & state_r.awready)
		begin
			state_nxt.aw_held = 1'b1;
			state_nxt.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & state_r.wready)
		begin
			state_nxt.w_held = 1'b1;
			state_nxt.wdata = s_axi_wdata;
			state_nxt.wstrb = s_axi_wstrb;
		end
		if (state_r.bvalid & s_axi_bready)
		begin
			state_nxt.bvalid = 1'b0;
		end
		if (link.link_ack)
		begin
			state_nxt.busy = 1'b0;
			state_nxt.last_rdata = link.link_rdata;
		end
		// perform a write once address and data are both held
		if (state_r.aw_held & state_r.w_held & !state_r.bvalid)
		begin
			state_nxt.aw_held = 1'b0;
			state_nxt.w_held = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = `CSWK_RESP_OKAY;
			unique case ({state_r.waddr[7:2], 2'b00})
				`CSWK_AXI_OFF_COMMAND:
				begin
					state_nxt.command = cmd;
					// a command issued while busy is dropped
					if (!state_r.busy)
					begin
						state_nxt.busy = 1'b1;
						state_nxt.link_req = 1'b1;
						state_nxt.link_write = !cmd[`CSWK_CMD_BIT_READ];
						state_nxt.link_addr = cmd[14:8];
						state_nxt.link_wdata = cmd[7:0];
					end
				end
				`CSWK_AXI_OFF_PIN:
				begin
					if (state_r.wstrb[0])
					begin
						state_nxt.tx_level = state_r.wdata[0];
					end
				end
				`CSWK_AXI_OFF_STATUS:
				begin
				end
				default: state_nxt.bresp = `CSWK_RESP_SLVERR;
			endcase
		end
		if (state_r.rvalid & s_axi_rready)
		begin
			state_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid & state_r.arready)
		begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp = `CSWK_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`CSWK_AXI_OFF_COMMAND: state_nxt.rdata = state_r.command;
				`CSWK_AXI_OFF_STATUS: state_nxt.rdata = {15'h0000,
					!link.interrupt_out_n, state_r.last_rdata, 7'h00, state_r.busy};
				`CSWK_AXI_OFF_PIN: state_nxt.rdata = {31'h00000000, state_r.tx_level};
				default:
				begin
					state_nxt.rdata = 32'h00000000;
					state_nxt.rresp = `CSWK_RESP_SLVERR;
				end
			endcase
		end
		state_nxt.awready = !state_nxt.aw_held & !state_nxt.bvalid;
		state_nxt.wready = !state_nxt.w_held & !state_nxt.bvalid;
		state_nxt.arready = !state_nxt.rvalid;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = state_r.awready;
	assign s_axi_wready = state_r.wready;
	assign s_axi_bvalid = state_r.bvalid;
	assign s_axi_bresp = state_r.bresp;
	assign s_axi_arready = state_r.arready;
	assign s_axi_rvalid = state_r.rvalid;
	assign s_axi_rdata = state_r.rdata;
	assign s_axi_rresp = state_r.rresp;
	assign link.link_req = state_r.link_req;
	assign link.link_write = state_r.link_write;
	assign link.link_addr = state_r.link_addr;
	assign link.link_wdata = state_r.link_wdata;
	assign link.bus_transmit_input = state_r.tx_level;

endmodule

// file: testbench/cswk_link_props.sv
// concurrent checks on the register link between controller and device
`timescale 1ns/10ps
module cswk_link_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic link_req,
	input wire logic link_write,
	input wire logic [6:0] link_addr,
	input wire logic [7:0] link_wdata,
	input wire logic [7:0] link_rdata,
	input wire logic link_ack,
	input wire logic bus_transmit_input,
	input wire logic interrupt_out_n
);
	logic wr;
	logic rd_ack;
	logic allow_r;
	logic dirty_r;
	logic [1:0] trim_r;
	logic [7:0] opt_r;

	assign wr = link_req && link_write;

	// ----------------------------------------
	// shadows of what the link has written
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			allow_r <= 1'b0;
			dirty_r <= 1'b0;
			trim_r <= 2'h0;
			opt_r <= 8'h00;
		end
		else if (wr)
		begin
			if (link_addr == 7'h20)
			begin
				allow_r <= link_wdata[4];
				trim_r <= link_wdata[6:5];
				dirty_r <= dirty_r && !link_wdata[0];
			end
			if ((link_addr > 7'h20 && link_addr < 7'h28) || (link_addr == 7'h4f && trim_r == 2'h3))
				dirty_r <= 1'b1;
			if (link_addr == 7'h4f && trim_r == 2'h3)
				opt_r <= link_wdata;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_ff @(posedge aclk)
	begin
		rd_ack <= link_req && !link_write;
	end

	AST_ACK_FOLLOWS: assert property (link_req |=> link_ack)
		else $error("link request not acknowledged next cycle");
	AST_ACK_NEEDS_REQ: assert property (link_ack |-> $past(link_req))
		else $error("link acknowledge without request");
	AST_CTRL_RSV: assert property (link_ack && rd_ack && $past(link_addr) == 7'h20
		|-> link_rdata[3:1] == 3'h0)
		else $error("control reserved bits not zero");
	AST_SAMPLE_RSV: assert property (link_ack && rd_ack && $past(link_addr) == 7'h22
		|-> link_rdata[7:6] == 2'h0)
		else $error("sample point reserved bits not zero");
	AST_LOW_RSV: assert property (link_ack && rd_ack && $past(link_addr) == 7'h26
		|-> !link_rdata[7])
		else $error("identifier low reserved bit not zero");
	AST_VALID_CLEARED: assert property (link_ack && rd_ack && $past(link_addr) == 7'h20
		&& $past(dirty_r) |-> !link_rdata[0])
		else $error("valid flag kept after configuration write");
	AST_OPT_LOCKED: assert property (link_ack && rd_ack && $past(link_addr) == 7'h4f
		|-> link_rdata == $past(opt_r))
		else $error("option register write lock broken");
	AST_IRQ_NEEDS_ALLOW: assert property (!interrupt_out_n |-> allow_r || $past(allow_r))
		else $error("interrupt while timeout masked");
endmodule

// file: testbench/tb_top.sv
// self-checking bench: AXI4-Lite into the controller, device joined by the link
`timescale 1ns/10ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic sreset = 1'b0, restart = 1'b0, wake = 1'b0, tout = 1'b0, fv = 1'b0, fide = 1'b0;
	logic frtr = 1'b0;
	logic [28:0] fid = 29'h0;
	logic osc, cref, wmatch;
	logic wen, tflag;
	logic [7:0] lpo;
	logic [1:0] bresp_v, rresp_v;
	logic [7:0] qpb;
	logic [5:0] spt;
	int err_count = 0;
	int samples_checked = 0;

	always #25 aclk = ~aclk;

	cswk_link_if u_cswk_link_if ();
	cswk_host u_cswk_host (.aclk(aclk), .aresetn(aresetn), .link(u_cswk_link_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cswk_device u_cswk_device (.aclk(aclk), .aresetn(aresetn), .link(u_cswk_link_if),
		.soft_reset(sreset), .chip_restart(restart), .wake_up_event(wake),
		.bus_timeout_event(tout), .rx_frame_valid(fv), .rx_ident(fid), .rx_rtr(frtr),
		.rx_ide(fide), .wake_enabled(wen), .osc_calibration_on(osc), .calib_reference(cref),
		.quanta_per_bit(qpb), .sample_point(spt), .low_power_rx_option_reg(lpo),
		.bus_timeout_flag(tflag), .wake_frame_match(wmatch));
	cswk_link_props u_props (.aclk(aclk), .aresetn(aresetn),
		.link_req(u_cswk_link_if.link_req), .link_write(u_cswk_link_if.link_write),
		.link_addr(u_cswk_link_if.link_addr), .link_wdata(u_cswk_link_if.link_wdata),
		.link_rdata(u_cswk_link_if.link_rdata), .link_ack(u_cswk_link_if.link_ack),
		.bus_transmit_input(u_cswk_link_if.bus_transmit_input),
		.interrupt_out_n(u_cswk_link_if.interrupt_out_n));

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_go, w_go, b_go;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_go = 1'b0;
		while (!b_go)
		begin
			@(negedge aclk);
			aw_go = awvalid && awready;
			w_go = wvalid && wready;
			b_go = (bvalid === 1'b1);
			bresp_v = bresp;
			@(posedge aclk);
			if (aw_go)
				awvalid <= 1'b0;
			if (w_go)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic ar_go, r_go;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_go = 1'b0;
		while (!r_go)
		begin
			@(negedge aclk);
			ar_go = arvalid && arready;
			r_go = (rvalid === 1'b1);
			rd_v = rdata;
			rresp_v = rresp;
			@(posedge aclk);
			if (ar_go)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic idle();
		do
			axi_rd(8'h04);
		while (rd_v[0] !== 1'b0);
	endtask

	task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
		axi_wr(8'h00, {16'h0000, 1'b0, a, d});
		idle();
	endtask

	task automatic dev_chk(input logic [6:0] a, input logic [7:0] e);
		axi_wr(8'h00, {15'h0000, 1'b1, 1'b0, a, 8'h00});
		idle();
		chk("device register", e, rd_v[15:8]);
	endtask

	task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
		dev_wr(a, d);
		dev_chk(a, e);
	endtask

	task automatic tpulse();
		@(posedge aclk);
		tout <= 1'b1;
		@(posedge aclk);
		tout <= 1'b0;
	endtask

	task automatic frame(input logic [28:0] id, input logic ide, input logic e);
		logic hit;
		@(posedge aclk);
		fid <= id;
		fide <= ide;
		fv <= 1'b1;
		@(posedge aclk);
		fv <= 1'b0;
		hit = 1'b0;
		repeat (3)
		begin
			@(negedge aclk);
			hit = hit | (wmatch === 1'b1);
		end
		chk("wake frame match", {7'h00, e}, {7'h00, hit});
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("quanta per bit", 8'ha0, qpb);
		chk("sample point", 8'h33, {2'b00, spt});
		dev_chk(7'h20, 8'h00);
		dev_chk(7'h22, 8'h33);
		wr_rd(7'h22, 8'hff, 8'h3f);
		wr_rd(7'h26, 8'hfd, 8'h7d);
		wr_rd(7'h21, 8'h55, 8'h55);
		chk("quanta per bit", 8'h55, qpb);
		wr_rd(7'h20, 8'hff, 8'hf1);
		chk("calibration", 8'h01, {7'h00, osc});
		wr_rd(7'h4f, 8'ha5, 8'ha5);
		chk("option register", 8'ha5, lpo);
		dev_chk(7'h20, 8'hf0);
		wr_rd(7'h20, 8'hb1, 8'hb1);
		chk("calibration", 8'h00, {7'h00, osc});
		wr_rd(7'h4f, 8'h0f, 8'ha5);
		chk("option register", 8'ha5, lpo);
		dev_wr(7'h20, 8'he0);
		axi_wr(8'h08, 32'h1);
		chk("write response", 8'h00, {6'h00, bresp_v});
		@(negedge aclk);
		chk("calibration reference", 8'h01, {7'h00, cref});
		axi_wr(8'h08, 32'h0);
		@(negedge aclk);
		chk("calibration reference", 8'h00, {7'h00, cref});
		axi_wr(8'h0c, 32'h0);
		chk("write response", 8'h02, {6'h00, bresp_v});
		axi_rd(8'h0c);
		chk("read response", 8'h02, {6'h00, rresp_v});
		wr_rd(7'h20, 8'h11, 8'h11);
		chk("wake enabled", 8'h01, {7'h00, wen});
		@(posedge aclk);
		wake <= 1'b1;
		@(posedge aclk);
		wake <= 1'b0;
		dev_chk(7'h20, 8'h10);
		chk("wake enabled", 8'h00, {7'h00, wen});
		tpulse();
		dev_chk(7'h4e, 8'h00);
		chk("timeout flag", 8'h00, {7'h00, tflag});
		dev_wr(7'h20, 8'h11);
		tpulse();
		dev_chk(7'h4e, 8'h01);
		chk("interrupt", 8'h00, {7'h00, u_cswk_link_if.interrupt_out_n});
		chk("interrupt status", 8'h01, {7'h00, rd_v[16]});
		chk("timeout flag", 8'h01, {7'h00, tflag});
		dev_wr(7'h4e, 8'h01);
		dev_wr(7'h20, 8'h01);
		tpulse();
		dev_chk(7'h4e, 8'h01);
		chk("interrupt", 8'h01, {7'h00, u_cswk_link_if.interrupt_out_n});
		chk("interrupt status", 8'h00, {7'h00, rd_v[16]});
		dev_wr(7'h23, 8'ha5);
		dev_wr(7'h24, 8'h3c);
		dev_wr(7'h25, 8'hc3);
		wr_rd(7'h26, 8'h29, 8'h29);
		wr_rd(7'h27, 8'hf0, 8'hf0);
		dev_wr(7'h20, 8'h01);
		frame({8'haa, 8'h3c, 8'hc3, 5'h0a}, 1'b1, 1'b1);
		frame({8'h55, 8'h3c, 8'hc3, 5'h0a}, 1'b1, 1'b0);
		frame({8'ha5, 8'h3c, 8'hc3, 5'h0b}, 1'b1, 1'b0);
		frame({8'ha5, 8'h3c, 8'hc3, 5'h0a}, 1'b0, 1'b0);
		@(posedge aclk);
		frtr <= 1'b1;
		frame({8'ha5, 8'h3c, 8'hc3, 5'h0a}, 1'b1, 1'b0);
		@(posedge aclk);
		frtr <= 1'b0;
		dev_wr(7'h26, 8'h28);
		dev_wr(7'h20, 8'h01);
		frame({8'ha5, 8'h3c, 8'h00, 5'h00}, 1'b0, 1'b1);
		frame({8'ha5, 8'h1c, 8'hc3, 5'h0a}, 1'b0, 1'b0);
		dev_wr(7'h20, 8'hf1);
		@(posedge aclk);
		restart <= 1'b1;
		@(posedge aclk);
		restart <= 1'b0;
		dev_chk(7'h20, 8'hf0);
		dev_chk(7'h21, 8'h55);
		@(posedge aclk);
		sreset <= 1'b1;
		@(posedge aclk);
		sreset <= 1'b0;
		dev_chk(7'h20, 8'h00);
		dev_chk(7'h21, 8'ha0);
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		report_and_stop();
	end
endmodule
